// ### psa_map.svh
`ifndef PSA_MAP_SVH
`define PSA_MAP_SVH

// store geometry
`define PSA_NUM_PARAMS   64
`define PSA_ADDR_W       6
`define PSA_DATA_W       32

// timing-class address bands, lowest address of each band above the immediate band (which starts at 0), then the last address of the map
`define PSA_STOP_BASE    6'h10
`define PSA_CFG_BASE     6'h20
`define PSA_POWER_BASE   6'h30
`define PSA_LAST_ADDR    6'h3f

// class encodings
`define PSA_CLS_IMM      2'h0
`define PSA_CLS_STOP     2'h1
`define PSA_CLS_CFG      2'h2
`define PSA_CLS_POWER    2'h3

`endif

// ### psa_pkg.sv
`include "psa_map.svh"

package psa_pkg;

    // when a written value becomes effective
    typedef enum logic [1:0] {
        CLS_IMM   = `PSA_CLS_IMM,
        CLS_STOP  = `PSA_CLS_STOP,
        CLS_CFG   = `PSA_CLS_CFG,
        CLS_POWER = `PSA_CLS_POWER
    } psa_class_type;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_LOAD   = 3'b001,
        ST_APPLY  = 3'b010,
        ST_SAVE   = 3'b011,
        ST_RECALC = 3'b100
    } psa_state_type;

    // each parameter address falls in exactly one class band
    function automatic psa_class_type psa_class_of(input logic [`PSA_ADDR_W-1:0] addr);
        if (addr >= `PSA_POWER_BASE) begin
            return CLS_POWER;
        end else if (addr >= `PSA_CFG_BASE) begin
            return CLS_CFG;
        end else if (addr >= `PSA_STOP_BASE) begin
            return CLS_STOP;
        end
        return CLS_IMM;
    endfunction

endpackage

// ### psa_nv_store.sv
`include "psa_map.svh"

// persistent parameter array; deliberately has no reset so contents survive
module psa_nv_store #(
    parameter int DEPTH  = `PSA_NUM_PARAMS,
    parameter int ADDR_W = `PSA_ADDR_W,
    parameter int DATA_W = `PSA_DATA_W
) (
    input  wire logic              core_clk,
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [DATA_W-1:0] wrData,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic      [DATA_W-1:0] rdData
);

    // blank part reads all zero until the first commit, so a load never copies unknowns
    logic [DATA_W-1:0] mem [DEPTH] = '{default: '0};

    // only the commit sweep writes here
    always_ff @(posedge core_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    assign rdData = mem[rdAddr];

endmodule // psa_nv_store

// ### psa_apply_ctrl.sv
`include "psa_map.svh"
module psa_apply_ctrl #(
    parameter int DEPTH  = `PSA_NUM_PARAMS,
    parameter int ADDR_W = `PSA_ADDR_W,
    parameter int DATA_W = `PSA_DATA_W
) (
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire logic              hostWrValid,
    input  wire logic [ADDR_W-1:0] hostWrAddr,
    input  wire logic [DATA_W-1:0] hostWrData,
    output logic                   hostWrReady,
    input  wire logic              motionStopped,
    input  wire logic              configCmd,
    input  wire logic              saveCmd,
    input  wire logic [ADDR_W-1:0] effRdAddr,
    output logic      [DATA_W-1:0] effRdData,
    output logic                   recalcPulse,
    output logic      [1:0]        recalcClass,
    output logic                   storeReady
);

    logic                       rstSync1;
    logic                       rstn;
    psa_pkg::psa_state_type     state;
    psa_pkg::psa_state_type     next_state;
    psa_pkg::psa_class_type     applyClass;
    psa_pkg::psa_class_type     next_applyClass;
    logic [ADDR_W-1:0]          idx;
    logic [DEPTH-1:0]           pending;
    logic                       cfgReq;
    logic                       saveReq;
    logic                       stopPending;
    logic                       accept;
    logic                       nvWrEn;
    logic [DATA_W-1:0]          nvRdData;
    logic [DATA_W-1:0]          workMem [DEPTH];
    logic [DATA_W-1:0]          effMem  [DEPTH];

    // reset released through two flops
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rstSync1 <= 1'b0;
            rstn     <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstn     <= rstSync1;
        end
    end

    assign accept = hostWrValid && hostWrReady;
    assign nvWrEn = (state == psa_pkg::ST_SAVE);

    // persistent copy, written by commit sweep only
    psa_nv_store #(
        .DEPTH  (DEPTH),
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W)
    ) u_nv (
        .core_clk (core_clk),
        .wrEn     (nvWrEn),
        .wrAddr   (idx),
        .wrData   (workMem[idx]),
        .rdAddr   (idx),
        .rdData   (nvRdData)
    );

    // any deferred after-stop value waiting
    always_comb begin
        stopPending = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            if (pending[i] && psa_pkg::psa_class_of(ADDR_W'(i)) == psa_pkg::CLS_STOP) begin
                stopPending = 1'b1;
            end
        end
    end

    // sequencer: config beats stop beats commit
    always_comb begin
        next_state      = state;
        next_applyClass = applyClass;
        unique case (state)
            psa_pkg::ST_IDLE: begin
                if (cfgReq) begin
                    next_state      = psa_pkg::ST_APPLY;
                    next_applyClass = psa_pkg::CLS_CFG;
                end else if (stopPending && motionStopped) begin
                    next_state      = psa_pkg::ST_APPLY;
                    next_applyClass = psa_pkg::CLS_STOP;
                end else if (saveReq) begin
                    next_state = psa_pkg::ST_SAVE;
                end
            end
            psa_pkg::ST_LOAD: begin
                if (idx == `PSA_LAST_ADDR) begin
                    next_state = psa_pkg::ST_RECALC;
                end
            end
            psa_pkg::ST_APPLY: begin
                if (idx == `PSA_LAST_ADDR) begin
                    next_state = psa_pkg::ST_RECALC;
                end
            end
            psa_pkg::ST_SAVE: begin
                if (idx == `PSA_LAST_ADDR) begin
                    next_state = psa_pkg::ST_IDLE;
                end
            end
            psa_pkg::ST_RECALC: begin
                next_state = psa_pkg::ST_IDLE;
            end
            default: begin
                next_state = psa_pkg::ST_IDLE;
            end
        endcase
    end

    // load starts straight out of reset
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state      <= psa_pkg::ST_LOAD;
            applyClass <= psa_pkg::CLS_POWER;
        end else begin
            state      <= next_state;
            applyClass <= next_applyClass;
        end
    end

    // sweep index, restarts at zero on every new sweep
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            idx <= '0;
        end else if (state == psa_pkg::ST_IDLE || state == psa_pkg::ST_RECALC) begin
            idx <= '0;
        end else begin
            idx <= idx + 1'b1;
        end
    end

    // writes blocked during sweeps so no entry changes mid-copy
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hostWrReady <= 1'b0;
        end else begin
            hostWrReady <= (next_state == psa_pkg::ST_IDLE);
        end
    end

    // command latches; a new command wins over the consuming clear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cfgReq  <= 1'b0;
            saveReq <= 1'b0;
        end else begin
            cfgReq  <= configCmd ||
                       (cfgReq && !(state == psa_pkg::ST_IDLE && next_state == psa_pkg::ST_APPLY &&
                                    next_applyClass == psa_pkg::CLS_CFG));
            saveReq <= saveCmd ||
                       (saveReq && !(state == psa_pkg::ST_IDLE && next_state == psa_pkg::ST_SAVE));
        end
    end

    // working copy: no reset, filled by the load sweep
    always_ff @(posedge core_clk) begin
        if (state == psa_pkg::ST_LOAD) begin
            workMem[idx] <= nvRdData;
        end else if (accept) begin
            workMem[hostWrAddr] <= hostWrData;
        end
    end

    // effective values seen by the motion logic
    always_ff @(posedge core_clk) begin
        if (state == psa_pkg::ST_LOAD) begin
            effMem[idx] <= nvRdData;
        end else if (accept && psa_pkg::psa_class_of(hostWrAddr) == psa_pkg::CLS_IMM) begin
            effMem[hostWrAddr] <= hostWrData;
        end else if (state == psa_pkg::ST_APPLY && pending[idx] &&
                     psa_pkg::psa_class_of(idx) == applyClass) begin
            effMem[idx] <= workMem[idx];
        end
    end

    // per-entry pending flag; power class is never swept, only cleared by reset
    generate
        for (genvar g = 0; g < DEPTH; g++) begin : gen_pend
            localparam logic [ADDR_W-1:0] ENTRY = ADDR_W'(g);
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    pending[g] <= 1'b0;
                end else if (accept && hostWrAddr == ENTRY &&
                             psa_pkg::psa_class_of(ENTRY) != psa_pkg::CLS_IMM) begin
                    pending[g] <= 1'b1;
                end else if (state == psa_pkg::ST_APPLY && idx == ENTRY &&
                             psa_pkg::psa_class_of(ENTRY) == applyClass) begin
                    pending[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // recalculation strobe: after load, after an apply sweep, and per immediate write
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            recalcPulse <= 1'b0;
            recalcClass <= 2'h0;
        end else if (state == psa_pkg::ST_RECALC) begin
            recalcPulse <= 1'b1;
            recalcClass <= applyClass;
        end else if (accept && psa_pkg::psa_class_of(hostWrAddr) == psa_pkg::CLS_IMM) begin
            recalcPulse <= 1'b1;
            recalcClass <= psa_pkg::CLS_IMM;
        end else begin
            recalcPulse <= 1'b0;
        end
    end

    // ready once the power-up pass is done
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            storeReady <= 1'b0;
        end else if (state == psa_pkg::ST_RECALC) begin
            storeReady <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        effRdData <= effMem[effRdAddr];
    end

    sequence seqLoadEnd;
        state == psa_pkg::ST_LOAD && idx == `PSA_LAST_ADDR;
    endsequence

    sequence seqRecalc;
        state == psa_pkg::ST_RECALC ##1 recalcPulse;
    endsequence

    AST_LOAD_COPIES: assert property (@(posedge core_clk) disable iff (!rstn)
        state == psa_pkg::ST_LOAD |=> workMem[$past(idx)] == $past(nvRdData))
        else $error("load sweep did not copy store entry");

    AST_LOAD_RECALC: assert property (@(posedge core_clk) disable iff (!rstn)
        seqLoadEnd |=> seqRecalc ##0 storeReady)
        else $error("no recalculation after power-up load");

    AST_NV_UNTOUCHED: assert property (@(posedge core_clk) disable iff (!rstn)
        accept |-> !nvWrEn)
        else $error("host write reached the nonvolatile store");

    AST_IMM_APPLY: assert property (@(posedge core_clk) disable iff (!rstn)
        accept && psa_pkg::psa_class_of(hostWrAddr) == psa_pkg::CLS_IMM
        |=> effMem[$past(hostWrAddr)] == $past(hostWrData) && recalcPulse)
        else $error("immediate value not applied next cycle");

    AST_DEFER_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
        accept && psa_pkg::psa_class_of(hostWrAddr) != psa_pkg::CLS_IMM
        |=> pending[$past(hostWrAddr)])
        else $error("deferred write not held pending");

    AST_STOP_GATE: assert property (@(posedge core_clk) disable iff (!rstn)
        state == psa_pkg::ST_IDLE && next_state == psa_pkg::ST_APPLY &&
        next_applyClass == psa_pkg::CLS_STOP |-> motionStopped && !cfgReq)
        else $error("after-stop apply started while moving");

    AST_CFG_GATE: assert property (@(posedge core_clk) disable iff (!rstn)
        state == psa_pkg::ST_APPLY && applyClass == psa_pkg::CLS_CFG && idx == '0
        |-> $past(cfgReq))
        else $error("config apply without a command");

    AST_POWER_NEVER: assert property (@(posedge core_clk) disable iff (!rstn)
        state == psa_pkg::ST_APPLY |-> applyClass != psa_pkg::CLS_POWER)
        else $error("power-cycle class applied at run time");

    AST_BUSY_BLOCK: assert property (@(posedge core_clk) disable iff (!rstn)
        state != psa_pkg::ST_IDLE |-> !hostWrReady)
        else $error("write accepted during a sweep");

    AST_SWEEP_LEN: assert property (@(posedge core_clk) disable iff (!rstn)
        state == psa_pkg::ST_IDLE ##1 state == psa_pkg::ST_APPLY
        |-> ##63 state == psa_pkg::ST_APPLY ##1 state == psa_pkg::ST_RECALC)
        else $error("apply sweep length wrong");

endmodule // psa_apply_ctrl

// ### psa_host_model.sv
// host on the serial link: one held write at a time, rare commits
module psa_host_model #(
    parameter int MAX_COMMITS = 4
) (
    input  wire logic        core_clk,
    input  wire logic        go,
    input  wire logic [5:0]  goAddr,
    input  wire logic [31:0] goData,
    input  wire logic        saveGo,
    input  wire logic        hostWrReady,
    output logic             hostWrValid,
    output logic      [5:0]  hostWrAddr,
    output logic      [31:0] hostWrData,
    output logic             saveCmd,
    output logic             accepted
);
    logic goSeen;
    logic saveArm;
    int   commits;

    initial begin
        hostWrValid = 1'b0;
        hostWrAddr = 6'h00;
        hostWrData = 32'h0;
        saveCmd = 1'b0;
        accepted = 1'b0;
        goSeen = 1'b0;
        saveArm = 1'b0;
        commits = 0;
    end

    // requests sampled on the rising edge so the falling-edge drive never races
    always @(posedge core_clk) begin
        goSeen <= go;
        saveArm <= saveGo;
        accepted <= hostWrValid && hostWrReady;
    end

    // held until taken, then released with inverted lines so stale data never looks valid
    always @(negedge core_clk) begin
        if (accepted) begin
            hostWrValid <= 1'b0;
            hostWrAddr <= ~hostWrAddr;
            hostWrData <= ~hostWrData;
        end else if (goSeen && !hostWrValid) begin
            hostWrValid <= 1'b1;
            hostWrAddr <= goAddr;
            hostWrData <= goData;
        end
    end

    // commits capped, the store wears out
    always @(negedge core_clk) begin
        saveCmd <= saveArm && !saveCmd && (commits < MAX_COMMITS);
        if (saveArm && !saveCmd && (commits < MAX_COMMITS)) begin
            commits <= commits + 1;
        end
    end
endmodule // psa_host_model

// ### testbench.sv
`include "psa_map.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        go = 1'b0;
    logic [5:0]  goAddr = 6'h00;
    logic [31:0] goData = 32'h0;
    logic        saveGo = 1'b0;
    logic        motionStopped = 1'b0;
    logic        configCmd = 1'b0;
    logic [5:0]  effRdAddr = 6'h00;
    logic        hostWrValid, hostWrReady, saveCmd, accepted;
    logic [5:0]  hostWrAddr;
    logic [31:0] hostWrData, effRdData;
    logic        recalcPulse, storeReady;
    logic [1:0]  recalcClass;
    logic [31:0] wrk[64], eff[64], nv[64];
    logic [63:0] pend = '0;
    logic [5:0]  probe[4] = '{6'h0f, `PSA_STOP_BASE, `PSA_CFG_BASE, `PSA_LAST_ADDR};
    int          seed = 52706;
    int          n_mismatch = 0;
    int          checks_done = 0;

    // 200 MHz
    always #2.5 core_clk = ~core_clk;

    psa_apply_ctrl psa_apply_ctrl_inst (.core_clk(core_clk), .resetn(resetn),
        .hostWrValid(hostWrValid), .hostWrAddr(hostWrAddr), .hostWrData(hostWrData),
        .hostWrReady(hostWrReady), .motionStopped(motionStopped), .configCmd(configCmd),
        .saveCmd(saveCmd), .effRdAddr(effRdAddr), .effRdData(effRdData),
        .recalcPulse(recalcPulse), .recalcClass(recalcClass), .storeReady(storeReady));

    psa_host_model psa_host_model_inst (.core_clk(core_clk), .go(go), .goAddr(goAddr),
        .goData(goData), .saveGo(saveGo), .hostWrReady(hostWrReady),
        .hostWrValid(hostWrValid), .hostWrAddr(hostWrAddr), .hostWrData(hostWrData),
        .saveCmd(saveCmd), .accepted(accepted));

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // bounded wait: 0 write taken, 1 recalc pulse, 2 store ready, 3 write ready
    task automatic wait_for(input int sel);
        int i;
        for (i = 0; i < 300; i++) begin
            @(negedge core_clk);
            if ((sel == 0 && accepted === 1'b1) || (sel == 1 && recalcPulse === 1'b1) ||
                (sel == 2 && storeReady === 1'b1) || (sel == 3 && hostWrReady === 1'b1)) begin
                break;
            end
        end
        if (i == 300) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask

    // only the immediate band answers with a pulse on the next cycle
    task automatic host_write(input logic [5:0] a, input logic [31:0] d);
        logic imm;
        imm = (a < `PSA_STOP_BASE);
        go = 1'b1;
        goAddr = a;
        goData = d;
        wait_for(0);
        wrk[a] = d;
        if (imm) eff[a] = d;
        else pend[a] = 1'b1;
        // the pulse stands only in the cycle right after the taking edge
        chk("recalcPulse", {31'h0, recalcPulse}, {31'h0, imm});
        if (imm) chk("recalcClass", {30'h0, recalcClass}, 32'h0);
        go = 1'b0;
        @(negedge core_clk);
    endtask

    task automatic rd_chk(input logic [5:0] a);
        effRdAddr = a;
        repeat (2) @(negedge core_clk);
        chk("effRdData", effRdData, eff[a]);
    endtask

    // pending entries of one 16-address band become effective
    task automatic apply_band(input logic [1:0] cls, input int lo);
        wait_for(1);
        chk("recalcClass", {30'h0, recalcClass}, {30'h0, cls});
        for (int k = lo; k < lo + 16; k++) begin
            if (pend[k]) eff[k] = wrk[k];
            pend[k] = 1'b0;
        end
    endtask

    // power cycle: only the nonvolatile copy survives
    task automatic power_cycle;
        resetn = 1'b0;
        repeat (3) @(negedge core_clk);
        chk("storeReady", {31'h0, storeReady}, 32'h0);
        resetn = 1'b1;
        eff = nv;
        wrk = nv;
        pend = '0;
        wait_for(2);
        chk("recalcPulse", {31'h0, recalcPulse}, 32'h1);
        chk("recalcClass", {30'h0, recalcClass}, 32'h3);
        chk("hostWrReady", {31'h0, hostWrReady}, 32'h1);
    endtask

    initial begin
        @(negedge core_clk);
        power_cycle();
        for (int a = 0; a < 64; a++) host_write(a[5:0], $random(seed));
        // one commit per batch keeps store wear low
        saveGo = 1'b1;
        @(negedge core_clk);
        saveGo = 1'b0;
        repeat (4) @(negedge core_clk);
        wait_for(3);
        nv = wrk;
        power_cycle();
        for (int a = 0; a < 64; a++) rd_chk(a[5:0]);
        for (int i = 0; i < 4; i++) host_write(probe[i], $random(seed));
        for (int i = 0; i < 4; i++) rd_chk(probe[i]);
        motionStopped = 1'b1;
        apply_band(psa_pkg::CLS_STOP, 16);
        motionStopped = 1'b0;
        for (int i = 0; i < 4; i++) rd_chk(probe[i]);
        configCmd = 1'b1;
        @(negedge core_clk);
        configCmd = 1'b0;
        apply_band(psa_pkg::CLS_CFG, 32);
        for (int i = 0; i < 4; i++) rd_chk(probe[i]);
        // unsaved writes are lost, the store kept the committed values
        power_cycle();
        for (int i = 0; i < 4; i++) rd_chk(probe[i]);
        tally_and_finish();
    end
endmodule // testbench
